// ### ldc_device.sv
// led driver configuration slave: two-wire write port and register bank
`timescale 1ns/100ps
`include "ldc_regs.svh"
module ldc_device
    import ldc_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  nrst_in,
    ldc_link_if.dev    link,
    input  wire logic  ring_sync_input_in,
    input  wire logic  strobe_input_in,
    output logic       active_select_out,
    output logic       pump_on_out,
    output logic [5:0] led_on_out,
    output logic [4:0] red1_level_out,
    output logic [4:0] green1_level_out,
    output logic [4:0] blue1_level_out,
    output logic [4:0] red2_level_out,
    output logic [4:0] green2_level_out,
    output logic [4:0] blue2_level_out,
    output logic       group1_sync_disable_out,
    output logic       group2_sync_disable_out,
    output logic [2:0] group1_ramp_up_out,
    output logic [2:0] group1_ramp_down_out,
    output logic [2:0] group2_ramp_up_out,
    output logic [2:0] group2_ramp_down_out,
    output logic [2:0] group1_cycle_period_out,
    output logic       group1_auto_toggle_out,
    output logic       group1_single_fade_out,
    output logic       group2_follow_out,
    output logic       strobe_active_out,
    output logic [5:0] led_drive_out
);
    logic                scl_s;
    logic                sda_s;
    logic                sync_s;
    logic                strobe_s;
    logic                scl_d_r;
    logic                sda_d_r;
    ldc_slave_state_type state_r;
    logic [3:0]          bit_cnt_r;
    logic [7:0]          shift_r;
    logic                have_ptr_r;
    logic [7:0]          ptr_r;
    logic                ack_drive_r;
    logic                byte_ok_r;
    logic [7:0]          regs_r [0:`LDC_NUM_REGS-1];
    logic                start_det;
    logic                stop_det;
    logic                scl_rise;
    logic                scl_fall;
    logic [7:0]          byte_nxt;

    // ================================================================
    // pin synchronisers
    ldc_sync3 u_scl (.clk_in(clk_in), .nrst_in(nrst_in), .pin_in(link.scl), .level_out(scl_s));
    ldc_sync3 u_sda (.clk_in(clk_in), .nrst_in(nrst_in), .pin_in(link.sda), .level_out(sda_s));
    ldc_sync3 u_syn (.clk_in(clk_in), .nrst_in(nrst_in), .pin_in(ring_sync_input_in),
                     .level_out(sync_s));
    ldc_sync3 u_stb (.clk_in(clk_in), .nrst_in(nrst_in), .pin_in(strobe_input_in),
                     .level_out(strobe_s));

    // ================================================================
    // edge and condition detection on the filtered lines
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign scl_rise  = scl_s && !scl_d_r;
    assign scl_fall  = !scl_s && scl_d_r;
    assign byte_nxt  = {shift_r[6:0], sda_s};

    // ================================================================
    // receive state machine; a start anywhere restarts address phase
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_r     <= LDC_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            have_ptr_r  <= 1'b0;
            ptr_r       <= 8'h00;
            ack_drive_r <= 1'b0;
            byte_ok_r   <= 1'b0;
        end else if (start_det) begin
            state_r     <= LDC_ADDR;
            bit_cnt_r   <= 4'h0;
            have_ptr_r  <= 1'b0;
            ack_drive_r <= 1'b0;
        end else if (stop_det) begin
            state_r     <= LDC_IDLE;
            ack_drive_r <= 1'b0;
        end else begin
            case (state_r)
                LDC_ADDR, LDC_DATA: begin
                    if (scl_rise) begin
                        shift_r   <= byte_nxt; // msb first
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h7) begin
                            if (state_r == LDC_ADDR) begin
                                // only our address with write direction
                                byte_ok_r <= (byte_nxt == {`LDC_SLAVE_ADDR, 1'b0});
                            end else begin
                                byte_ok_r <= 1'b1;
                            end
                        end
                    end else if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= 4'h0;
                        if (byte_ok_r) begin
                            state_r     <= LDC_ACK;
                            ack_drive_r <= 1'b1; // pull low after eighth fall
                            if (state_r == LDC_DATA) begin
                                have_ptr_r <= 1'b1;
                                ptr_r      <= have_ptr_r ? ptr_r + 8'h01 : shift_r;
                            end
                        end else begin
                            state_r <= LDC_IGNORE;
                        end
                    end
                end
                LDC_ACK: begin
                    if (scl_fall) begin
                        ack_drive_r <= 1'b0; // release at ninth fall
                        state_r     <= LDC_DATA;
                    end
                end
                default: begin
                    bit_cnt_r <= 4'h0;
                end
            endcase
        end
    end

    assign link.sda_dev_o  = 1'b0;
    assign link.sda_dev_oe = ack_drive_r;

    // ================================================================
    // register writes: the byte after the pointer byte lands in ptr_r,
    // later bytes auto-advance; unmapped offsets are dropped
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < `LDC_NUM_REGS; i++) begin
                regs_r[i] <= `LDC_REG_RESET;
            end
        end else if (state_r == LDC_DATA && scl_fall && bit_cnt_r == 4'h8 && have_ptr_r) begin
            if (ptr_r == `LDC_OFS_POWER) begin
                regs_r[0] <= shift_r;
            end else if (ptr_r == `LDC_OFS_RED1 || ptr_r == `LDC_OFS_RED2) begin
                regs_r[ptr_r[3:0]] <= shift_r & `LDC_MASK_LEVEL;
            end else if (ptr_r == `LDC_OFS_GREEN1 || ptr_r == `LDC_OFS_BLUE1 ||
                         ptr_r == `LDC_OFS_GREEN2 || ptr_r == `LDC_OFS_BLUE2) begin
                regs_r[ptr_r[3:0]] <= shift_r & 8'h1F;
            end else if (ptr_r == `LDC_OFS_G1_SLOPE || ptr_r == `LDC_OFS_G2_SLOPE) begin
                regs_r[ptr_r[3:0]] <= shift_r & `LDC_MASK_SLOPE;
            end else if (ptr_r == `LDC_OFS_G1_CYCLE) begin
                regs_r[9] <= shift_r & `LDC_MASK_CYCLE;
            end
        end
    end

    // ================================================================
    // field outputs; led switches read out raw here, gated by active only at led_drive_out below
    assign active_select_out       = regs_r[0][`LDC_BIT_ACTIVE];
    assign pump_on_out             = regs_r[0][`LDC_BIT_PUMP];
    assign led_on_out              = regs_r[0][7:2];
    assign red1_level_out          = regs_r[1][4:0];
    assign green1_level_out        = regs_r[2][4:0];
    assign blue1_level_out         = regs_r[3][4:0];
    assign red2_level_out          = regs_r[4][4:0];
    assign green2_level_out        = regs_r[5][4:0];
    assign blue2_level_out         = regs_r[6][4:0];
    assign group1_sync_disable_out = regs_r[1][`LDC_BIT_SYNC_DIS];
    assign group2_sync_disable_out = regs_r[4][`LDC_BIT_SYNC_DIS];
    assign group1_ramp_up_out      = regs_r[7][2:0];
    assign group1_ramp_down_out    = regs_r[7][5:3];
    assign group2_ramp_up_out      = regs_r[8][2:0];
    assign group2_ramp_down_out    = regs_r[8][5:3];
    // code 7 means ramp of half the period; the analog fade engine scales it
    assign group1_cycle_period_out = regs_r[9][2:0];
    assign group1_auto_toggle_out  = regs_r[9][`LDC_BIT_AUTO];
    assign group1_single_fade_out  = regs_r[9][`LDC_BIT_SINGLE];
    assign group2_follow_out       = regs_r[9][`LDC_BIT_FOLLOW];

    // ================================================================
    // output gating: sync, when effective, overrides switches even in strobe
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            led_drive_out     <= 6'h00;
            strobe_active_out <= 1'b0;
        end else begin
            strobe_active_out <= strobe_s && regs_r[0][`LDC_BIT_ACTIVE];
            for (int k = 0; k < 6; k++) begin
                if (!regs_r[0][`LDC_BIT_ACTIVE]) begin
                    led_drive_out[k] <= 1'b0;
                end else if (!regs_r[(k < 3) ? 1 : 4][`LDC_BIT_SYNC_DIS]) begin
                    led_drive_out[k] <= regs_r[0][k+2] && sync_s;
                end else begin
                    led_drive_out[k] <= regs_r[0][k+2];
                end
            end
        end
    end
endmodule

// ### ldc_host.sv
// two-wire host: apb command register, sends three-byte register writes
`timescale 1ns/100ps
`include "ldc_regs.svh"
module ldc_host
    import ldc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    ldc_link_if.host         link
);
    localparam int QCYC = `LDC_QUARTER_CYC;
    ldc_host_state_type state_r;
    logic [7:0]  addr_byte_r;
    logic [7:0]  data_byte_r;
    logic        busy_r;
    logic        nack_r;
    logic [1:0]  byte_idx_r;
    logic [3:0]  bit_r;
    logic [1:0]  phase_r;
    logic [7:0]  tick_r;
    logic [7:0]  cur_byte;
    logic        sda_s;
    logic        wr_cmd;
    logic        tick;

    ldc_sync3 u_sda (.clk_in(clk_in), .nrst_in(nrst_in), .pin_in(link.sda), .level_out(sda_s));

    // ================================================================
    // apb slave: cmd = {addr[15:8], data[7:0]}, status = {nack, busy}
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(paddr == `LDC_APB_CMD || paddr == `LDC_APB_STATUS);
    assign wr_cmd  = psel && penable && pwrite && paddr == `LDC_APB_CMD && !busy_r;
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `LDC_APB_STATUS) begin
            prdata = {30'h0, nack_r, busy_r};
        end else if (paddr == `LDC_APB_CMD) begin
            prdata = {16'h0, addr_byte_r, data_byte_r};
        end
    end

    assign tick     = (tick_r == 8'(QCYC - 1));
    assign cur_byte = (byte_idx_r == 2'd0) ? {`LDC_SLAVE_ADDR, 1'b0} :
                      (byte_idx_r == 2'd1) ? addr_byte_r : data_byte_r;

    // ================================================================
    // bit engine: four quarter phases per scl period; data changes only
    // while scl is low
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_r          <= LDC_H_IDLE;
            addr_byte_r      <= 8'h00;
            data_byte_r      <= 8'h00;
            busy_r           <= 1'b0;
            nack_r           <= 1'b0;
            byte_idx_r       <= 2'd0;
            bit_r            <= 4'h0;
            phase_r          <= 2'd0;
            tick_r           <= 8'h00;
            link.scl_o       <= 1'b1;
            link.scl_oe      <= 1'b0;
            link.sda_host_o  <= 1'b1;
            link.sda_host_oe <= 1'b0;
        end else begin
            tick_r <= (state_r == LDC_H_IDLE || tick) ? 8'h00 : tick_r + 8'h01;
            case (state_r)
                LDC_H_IDLE: begin
                    if (wr_cmd) begin
                        addr_byte_r <= pwdata[15:8];
                        data_byte_r <= pwdata[7:0];
                        busy_r      <= 1'b1;
                        nack_r      <= 1'b0;
                        state_r     <= LDC_H_START;
                        phase_r     <= 2'd0;
                    end
                end
                LDC_H_START: begin
                    if (tick) begin
                        link.sda_host_oe <= 1'b1;
                        link.sda_host_o  <= 1'b0; // fall while scl high
                        phase_r          <= phase_r + 2'd1;
                        if (phase_r == 2'd1) begin
                            link.scl_oe <= 1'b1;
                            link.scl_o  <= 1'b0;
                            state_r     <= LDC_H_BIT;
                            byte_idx_r  <= 2'd0;
                            bit_r       <= 4'h0;
                            phase_r     <= 2'd0;
                        end
                    end
                end
                LDC_H_BIT, LDC_H_ACK: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        case (phase_r)
                            2'd0: begin
                                if (state_r == LDC_H_BIT) begin
                                    link.sda_host_oe <= !cur_byte[3'(7 - bit_r)];
                                    link.sda_host_o  <= 1'b0;
                                end else begin
                                    link.sda_host_oe <= 1'b0; // release for ack
                                end
                            end
                            2'd1: link.scl_oe <= 1'b0;
                            2'd2: begin
                                if (state_r == LDC_H_ACK && sda_s) begin
                                    nack_r <= 1'b1;
                                end
                            end
                            default: begin
                                link.scl_oe <= 1'b1;
                                if (state_r == LDC_H_BIT) begin
                                    bit_r <= bit_r + 4'h1;
                                    if (bit_r == 4'h7) begin
                                        state_r <= LDC_H_ACK;
                                    end
                                end else if (nack_r || byte_idx_r == 2'd2) begin
                                    state_r <= LDC_H_STOP;
                                end else begin
                                    state_r    <= LDC_H_BIT;
                                    bit_r      <= 4'h0;
                                    byte_idx_r <= byte_idx_r + 2'd1;
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        if (phase_r == 2'd0) begin
                            link.sda_host_oe <= 1'b1;
                            link.sda_host_o  <= 1'b0;
                        end else if (phase_r == 2'd1) begin
                            link.scl_oe <= 1'b0;
                        end else if (phase_r == 2'd2) begin
                            link.sda_host_oe <= 1'b0; // rise while scl high
                        end else begin
                            busy_r  <= 1'b0;
                            state_r <= LDC_H_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ### ldc_link_checker.sv
// assertions on the two-wire link between the led config host and device
`timescale 1ns/100ps
module ldc_link_checker (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ====================================
    // acknowledge length counter
    logic [7:0] ack_len_r;
    // saturates so a stuck acknowledge cannot wrap back under the limit
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !sda_dev_oe) ack_len_r <= 8'h00;
        else if (ack_len_r != 8'hFF) ack_len_r <= ack_len_r + 8'h01;
    end
    // ====================================
    // properties
    property p_rst_idle; disable iff (1'b0) !nrst_in |=> scl && sda && !sda_dev_oe; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    property p_ack_low; sda_dev_oe |-> !sda_dev_o && !sda; endproperty
    a_ack_low: assert property (p_ack_low) else $error("acknowledge not low");
    property p_ack_start; $rose(sda_dev_oe) |-> !scl; endproperty
    a_ack_start: assert property (p_ack_start) else $error("acknowledge began with clock high");
    property p_ack_end; $fell(sda_dev_oe) |-> !scl; endproperty
    a_ack_end: assert property (p_ack_end) else $error("acknowledge ended with clock high");
    property p_ack_len; ack_len_r < 8'h78; endproperty
    a_ack_len: assert property (p_ack_len) else $error("acknowledge held too long");
    property p_ack_hold; $rose(sda_dev_oe) |-> sda_dev_oe[*8]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge too short");
    property p_dev_quiet; scl && $past(scl) |-> $stable(sda_dev_oe); endproperty
    a_dev_quiet: assert property (p_dev_quiet) else $error("device moved data while clock high");
    property p_scl_low; $fell(scl) |-> !scl[*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
    property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
    property p_start_free; scl && $past(scl) && $fell(sda) |-> !sda_dev_oe; endproperty
    a_start_free: assert property (p_start_free) else $error("device held data at start");
endmodule

// ### ldc_link_if.sv
// two-wire link between the led configuration host and the device
`timescale 1ns/100ps
interface ldc_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    wire  scl;
    wire  sda;
    // open-drain wired-and with pull-ups
    assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o)) ? 1'b0 : 1'b1;
    modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe, input sda);
    modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface

// ### ldc_pkg.sv
// types shared by both ends of the led config link
package ldc_pkg;
    typedef enum logic [2:0] {
        LDC_IDLE, LDC_ADDR, LDC_ACK, LDC_DATA, LDC_IGNORE
    } ldc_slave_state_type;
    typedef enum logic [2:0] {
        LDC_H_IDLE, LDC_H_START, LDC_H_BIT, LDC_H_ACK, LDC_H_STOP
    } ldc_host_state_type;
endpackage

// ### ldc_regs.svh
// register offsets, field positions, reset values and timing counts for the led config link
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH
`define LDC_SLAVE_ADDR      7'h75
`define LDC_OFS_POWER       8'h00
`define LDC_OFS_RED1        8'h01
`define LDC_OFS_GREEN1      8'h02
`define LDC_OFS_BLUE1       8'h03
`define LDC_OFS_RED2        8'h04
`define LDC_OFS_GREEN2      8'h05
`define LDC_OFS_BLUE2       8'h06
`define LDC_OFS_G1_SLOPE    8'h07
`define LDC_OFS_G2_SLOPE    8'h08
`define LDC_OFS_G1_CYCLE    8'h09
`define LDC_NUM_REGS        10
`define LDC_REG_RESET       8'h00
`define LDC_BIT_ACTIVE      0
`define LDC_BIT_PUMP        1
`define LDC_BIT_SYNC_DIS    7
`define LDC_MASK_LEVEL      8'h9F
`define LDC_MASK_SLOPE      8'h3F
`define LDC_MASK_CYCLE      8'h3F
`define LDC_BIT_AUTO        3
`define LDC_BIT_SINGLE      4
`define LDC_BIT_FOLLOW      5
// host link timing: quarter of an scl period, 2.5 us at 100 ns clock
`define LDC_QUARTER_NS      2500
`define LDC_CLK_NS          100
`define LDC_QUARTER_CYC     (`LDC_QUARTER_NS / `LDC_CLK_NS)
// host command register map on apb
`define LDC_APB_CMD         12'h000
`define LDC_APB_STATUS      12'h004
`endif

// ### ldc_sync3.sv
// three-stage pin synchroniser; output changes when stages two and three agree
`timescale 1ns/100ps
module ldc_sync3 (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // ================================================================
    // stages; reset to idle-high as the bus rests high
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s1_r      <= 1'b1;
            s2_r      <= 1'b1;
            s3_r      <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// ### test_led_driver_config_regs.sv
// self-checking bench: apb host writes device registers over the two-wire link
`timescale 1ns/100ps
`include "ldc_regs.svh"
module test_led_driver_config_regs;
    logic        clk_in = 1'b0;
    logic        nrst_in, psel, penable, pwrite, sync_r, strobe_r, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, st;
    logic [7:0]  mdl [10];
    int          fails = 0;
    int          num_checks = 0;
    // ====================================
    // clock, link and both ends
    always #50 clk_in = ~clk_in;
    ldc_link_if lnk();
    ldc_host i_ldc_host (.clk_in(clk_in), .nrst_in(nrst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.host));
    ldc_device i_ldc_device (.clk_in(clk_in), .nrst_in(nrst_in), .link(lnk.dev), .ring_sync_input_in(sync_r),
        .strobe_input_in(strobe_r), .active_select_out(), .pump_on_out(), .led_on_out(), .red1_level_out(),
        .green1_level_out(), .blue1_level_out(), .red2_level_out(), .green2_level_out(), .blue2_level_out(),
        .group1_sync_disable_out(), .group2_sync_disable_out(), .group1_ramp_up_out(), .group1_ramp_down_out(),
        .group2_ramp_up_out(), .group2_ramp_down_out(), .group1_cycle_period_out(), .group1_auto_toggle_out(),
        .group1_single_fade_out(), .group2_follow_out(), .strobe_active_out(), .led_drive_out());
    ldc_link_checker i_ldc_link_checker (.clk_in(clk_in), .nrst_in(nrst_in), .scl(lnk.scl), .sda(lnk.sda),
        .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe));
    // ====================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // writable bits of each register; the rest always read back zero
    function automatic logic [7:0] mask_of(input int i);
        return (i == 0) ? 8'hFF : (i == 1 || i == 4) ? 8'h9F : (i >= 7) ? 8'h3F : 8'h1F;
    endfunction
    // rebuild each register from the device's field outputs
    function automatic logic [7:0] dut_reg(input int i);
        case (i)
            0: return {i_ldc_device.led_on_out, i_ldc_device.pump_on_out, i_ldc_device.active_select_out};
            1: return {i_ldc_device.group1_sync_disable_out, 2'b00, i_ldc_device.red1_level_out};
            2: return {3'b000, i_ldc_device.green1_level_out};
            3: return {3'b000, i_ldc_device.blue1_level_out};
            4: return {i_ldc_device.group2_sync_disable_out, 2'b00, i_ldc_device.red2_level_out};
            5: return {3'b000, i_ldc_device.green2_level_out};
            6: return {3'b000, i_ldc_device.blue2_level_out};
            7: return {2'b00, i_ldc_device.group1_ramp_down_out, i_ldc_device.group1_ramp_up_out};
            8: return {2'b00, i_ldc_device.group2_ramp_down_out, i_ldc_device.group2_ramp_up_out};
            default: return {2'b00, i_ldc_device.group2_follow_out, i_ldc_device.group1_single_fade_out,
                i_ldc_device.group1_auto_toggle_out, i_ldc_device.group1_cycle_period_out};
        endcase
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // one idle edge, so a following call never reassigns psel in this time step
        @(posedge clk_in);
        if (n >= 50) begin fails++; wrap_up(); end
    endtask
    task automatic wait_idle();
        int n;
        logic e;
        n = 0;
        do begin apb(1'b0, `LDC_APB_STATUS, 32'h0, st, e); n++; end while (st[0] !== 1'b0 && n < 4000);
        if (n >= 4000) begin fails++; wrap_up(); end
    endtask
    task automatic check_all();
        for (int i = 0; i < 10; i++) cmp({24'h0, dut_reg(i)}, {24'h0, mdl[i]});
    endtask
    // led gating from the model: an effective sync gates its group, standby forces all off
    task automatic cmp_out();
        logic [5:0] d;
        for (int k = 0; k < 6; k++) d[k] = mdl[0][0] && mdl[0][k+2] && (mdl[(k < 3) ? 1 : 4][7] || sync_r);
        cmp({26'h0, i_ldc_device.led_drive_out}, {26'h0, d});
        cmp({31'h0, i_ldc_device.strobe_active_out}, {31'h0, strobe_r && mdl[0][0]});
    endtask
    // send one register write and compare the whole bank afterwards
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] q;
        logic        e;
        wait_idle();
        apb(1'b1, `LDC_APB_CMD, {16'h0000, a, v}, q, e);
        wait_idle();
        cmp({31'h0, st[1]}, 32'h0);
        if (a < 8'h0A) mdl[a] = v & mask_of(a);
        sync_r <= seed[3];
        strobe_r <= seed[9];
        // three sync stages, the agreement stage and the output flop must pass
        repeat (6) @(posedge clk_in);
        check_all();
        cmp_out();
    endtask
    // ====================================
    // main sequence
    initial begin
        logic [31:0] q;
        logic        e;
        nrst_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        sync_r = 1'b0; strobe_r = 1'b0; seed = 32'h0F4D59DE;
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        check_all();
        for (int i = 0; i < 10; i++) wr_reg(i[7:0], 8'hFF);
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            wr_reg(i[7:0], seed[7:0]);
        end
        wr_reg(8'h0C, 8'h5A);
        // unmapped apb address must be refused
        apb(1'b0, 12'h008, 32'h0, q, e);
        cmp({31'h0, e}, 32'h1);
        // reset in mid-run must clear the bank again
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        foreach (mdl[i]) mdl[i] = 8'h00;
        check_all();
        cmp_out();
        wrap_up();
    end
endmodule
